// ===== sbo_pkg.sv
// shared constants and types for the store buffer and ordering block
package sbo_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   // write buffer depth, its pointer width and the width of its fill level
   localparam int WB_DEPTH = 4;
   localparam int PTR_W = 2;
   localparam int LVL_W = 3;
   localparam logic [LVL_W-1:0] LVL_FULL = 3'h4;
   localparam logic [LVL_W-1:0] LVL_LAST = 3'h3;
   // word granular matching: the low address bits select bytes
   localparam int WORD_LSB = 2;
   // reset values
   localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
   localparam logic [PTR_W-1:0] PTR_RST = 2'h0;
   localparam logic [LVL_W-1:0] LVL_RST = 3'h0;

   // core request codes
   typedef enum logic [2:0] {
      op_load = 3'b000,
      op_store = 3'b001,
      op_io_rd = 3'b010,
      op_io_wr = 3'b011,
      op_serialize = 3'b100,
      op_lock_rmw = 3'b101,
      op_int_ack = 3'b110
   } req_op_t;

   typedef enum logic [3:0] {
      st_idle = 4'b0000,
      st_rd = 4'b0001,
      st_wb = 4'b0010,
      st_flush = 4'b0011,
      st_io_wr = 4'b0100,
      st_lk_rd = 4'b0101,
      st_lk_wr = 4'b0110,
      st_cache = 4'b0111
   } ctl_state_t;
endpackage

// ===== wbuf_if.sv
// carrier between the ordering control and its write buffer
`timescale 1ns/1ps
interface wbuf_if;
   logic push;
   logic [sbo_pkg::ADDR_W-1:0] push_addr;
   logic [sbo_pkg::DATA_W-1:0] push_data;
   logic pop;
   logic [sbo_pkg::ADDR_W-1:0] head_addr;
   logic [sbo_pkg::DATA_W-1:0] head_data;
   logic empty;
   logic [sbo_pkg::LVL_W-1:0] level;
   logic [sbo_pkg::ADDR_W-1:0] look_addr;
   logic fwd_hit;
   logic [sbo_pkg::DATA_W-1:0] fwd_data;

   modport ctl (
      output push, push_addr, push_data, pop, look_addr,
      input head_addr, head_data, empty, level, fwd_hit, fwd_data
   );
   modport buf_side (
      input push, push_addr, push_data, pop, look_addr,
      output head_addr, head_data, empty, level, fwd_hit, fwd_data
   );
endinterface

// ===== store_fifo.sv
// in-order write buffer with store-to-load forwarding lookup
`timescale 1ns/1ps
module store_fifo (
   input wire logic clk,
   input wire logic rst_n,
   wbuf_if.buf_side wb
);
   logic [sbo_pkg::ADDR_W-1:0] addr_mem [sbo_pkg::WB_DEPTH];
   logic [sbo_pkg::DATA_W-1:0] data_mem [sbo_pkg::WB_DEPTH];
   logic [sbo_pkg::PTR_W-1:0] wr_ptr_r, wr_ptr_nxt;
   logic [sbo_pkg::PTR_W-1:0] rd_ptr_r, rd_ptr_nxt;
   logic [sbo_pkg::LVL_W-1:0] level_r, level_nxt;
   logic [sbo_pkg::PTR_W-1:0] idx;

   assign wb.head_addr = addr_mem[rd_ptr_r];
   assign wb.head_data = data_mem[rd_ptr_r];
   assign wb.empty = (level_r == sbo_pkg::LVL_RST);
   assign wb.level = level_r;

   // fifo order: entries leave only from the oldest slot
   always_comb begin
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      level_nxt = level_r;
      if (wb.push && level_r != sbo_pkg::LVL_FULL) begin
         wr_ptr_nxt = wr_ptr_r + 2'h1;
         level_nxt = level_nxt + 3'h1;
      end
      if (wb.pop && !wb.empty) begin
         rd_ptr_nxt = rd_ptr_r + 2'h1;
         level_nxt = level_nxt - 3'h1;
      end
   end

   // youngest match: later entries overwrite the earlier hit
   always_comb begin
      wb.fwd_hit = 1'b0;
      wb.fwd_data = sbo_pkg::DATA_RST;
      idx = rd_ptr_r;
      for (int i = 0; i < sbo_pkg::WB_DEPTH; i++) begin
         idx = rd_ptr_r + i[sbo_pkg::PTR_W-1:0];
         if (i < int'(level_r) && addr_mem[idx][sbo_pkg::ADDR_W-1:sbo_pkg::WORD_LSB] ==
             wb.look_addr[sbo_pkg::ADDR_W-1:sbo_pkg::WORD_LSB]) begin
            wb.fwd_hit = 1'b1;
            wb.fwd_data = data_mem[idx];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr_r <= sbo_pkg::PTR_RST;
         rd_ptr_r <= sbo_pkg::PTR_RST;
         level_r <= sbo_pkg::LVL_RST;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         level_r <= level_nxt;
      end
   end

   // storage needs no reset: the fill level masks stale slots
   always_ff @(posedge clk) begin
      if (wb.push && level_r != sbo_pkg::LVL_FULL) begin
         addr_mem[wr_ptr_r] <= wb.push_addr;
         data_mem[wr_ptr_r] <= wb.push_data;
      end
   end
endmodule // store_fifo

// ===== store_buffer_ordering_lock.sv
// write buffer, load/store ordering and locked read-modify-write control
`timescale 1ns/1ps
// Function
// - buffered stores drain to memory strictly oldest first.
// - only memory stores are buffered; I/O writes go straight to the bus.
// - a memory store retires at once, before its bus write completes.
// - port output and serializing ops wait until all buffered stores complete.
// - memory reads issue one at a time, in request order, none speculatively.
// - a read may reach the bus ahead of older buffered stores.
// - locked access inside one line updates the cache only, no bus lock.
// - locked access across two lines holds bus lock over the whole sequence.
// - lock covers at least the destination bytes, possibly more.
// - lock accepted at any privilege, no privilege comparison or fault.
// - bus lock stays low during interrupt acknowledge and vector fetch.
module store_buffer_ordering_lock (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire sbo_pkg::req_op_t req_op,
   input wire logic [sbo_pkg::ADDR_W-1:0] req_addr,
   input wire logic [sbo_pkg::DATA_W-1:0] req_wdata,
   input wire logic req_split,
   output logic req_ready,
   output logic rsp_valid,
   output logic [sbo_pkg::DATA_W-1:0] rsp_rdata,
   output logic bus_req,
   output logic bus_write,
   output logic bus_io,
   output logic bus_lock,
   output logic bus_inta,
   output logic [sbo_pkg::ADDR_W-1:0] bus_addr,
   output logic [sbo_pkg::DATA_W-1:0] bus_wdata,
   input wire logic bus_ack,
   input wire logic [sbo_pkg::DATA_W-1:0] bus_rdata,
   output logic cache_req,
   output logic [sbo_pkg::ADDR_W-1:0] cache_addr,
   output logic [sbo_pkg::DATA_W-1:0] cache_wdata,
   input wire logic cache_ack,
   input wire logic [sbo_pkg::DATA_W-1:0] cache_rdata
);
   wbuf_if wb ();

   sbo_pkg::ctl_state_t state_r, state_nxt;
   sbo_pkg::req_op_t op_r, op_nxt;
   logic [sbo_pkg::ADDR_W-1:0] addr_r, addr_nxt;
   logic [sbo_pkg::DATA_W-1:0] wdata_r, wdata_nxt;
   logic split_r, split_nxt;
   logic flushing_r, flushing_nxt;
   logic ready_r, ready_nxt;
   logic rsp_valid_r, rsp_valid_nxt;
   logic [sbo_pkg::DATA_W-1:0] rsp_data_r, rsp_data_nxt;
   logic bus_req_r, bus_req_nxt;
   logic bus_write_r, bus_write_nxt;
   logic bus_io_r, bus_io_nxt;
   logic bus_lock_r, bus_lock_nxt;
   logic bus_inta_r, bus_inta_nxt;
   logic [sbo_pkg::ADDR_W-1:0] bus_addr_r, bus_addr_nxt;
   logic [sbo_pkg::DATA_W-1:0] bus_wdata_r, bus_wdata_nxt;
   logic cache_req_r, cache_req_nxt;
   logic [sbo_pkg::ADDR_W-1:0] cache_addr_r, cache_addr_nxt;
   logic [sbo_pkg::DATA_W-1:0] cache_wdata_r, cache_wdata_nxt;
   logic accept;

   store_fifo u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .wb(wb)
   );

   assign req_ready = ready_r;
   assign rsp_valid = rsp_valid_r;
   assign rsp_rdata = rsp_data_r;
   assign bus_req = bus_req_r;
   assign bus_write = bus_write_r;
   assign bus_io = bus_io_r;
   assign bus_lock = bus_lock_r;
   assign bus_inta = bus_inta_r;
   assign bus_addr = bus_addr_r;
   assign bus_wdata = bus_wdata_r;
   assign cache_req = cache_req_r;
   assign cache_addr = cache_addr_r;
   assign cache_wdata = cache_wdata_r;

   assign accept = req_valid && ready_r && state_r == sbo_pkg::st_idle;

   always_comb begin
      state_nxt = state_r;
      op_nxt = op_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      split_nxt = split_r;
      flushing_nxt = flushing_r;
      ready_nxt = ready_r;
      rsp_valid_nxt = 1'b0;
      rsp_data_nxt = rsp_data_r;
      bus_req_nxt = bus_req_r;
      bus_write_nxt = bus_write_r;
      bus_io_nxt = bus_io_r;
      bus_lock_nxt = bus_lock_r;
      bus_inta_nxt = bus_inta_r;
      bus_addr_nxt = bus_addr_r;
      bus_wdata_nxt = bus_wdata_r;
      cache_req_nxt = cache_req_r;
      cache_addr_nxt = cache_addr_r;
      cache_wdata_nxt = cache_wdata_r;
      wb.push = 1'b0;
      wb.pop = 1'b0;
      wb.push_addr = req_addr;
      wb.push_data = req_wdata;
      wb.look_addr = req_addr;
      unique case (state_r)
         sbo_pkg::st_idle: begin
            if (accept) begin
               op_nxt = req_op;
               addr_nxt = req_addr;
               wdata_nxt = req_wdata;
               split_nxt = req_split;
               ready_nxt = 1'b0;
               unique case (req_op)
                  sbo_pkg::op_store: begin
                     // store retires: queued, core keeps going
                     wb.push = 1'b1;
                     ready_nxt = (wb.level < sbo_pkg::LVL_LAST);
                  end
                  sbo_pkg::op_load: begin
                     // own store seen: answered from the buffer
                     if (wb.fwd_hit) begin
                        rsp_valid_nxt = 1'b1;
                        rsp_data_nxt = wb.fwd_data;
                        ready_nxt = 1'b1;
                     end else begin
                        // read passes stores: buffered writes stay queued
                        state_nxt = sbo_pkg::st_rd;
                        bus_req_nxt = 1'b1;
                        bus_write_nxt = 1'b0;
                        bus_io_nxt = 1'b0;
                        bus_addr_nxt = req_addr;
                     end
                  end
                  sbo_pkg::op_io_rd: begin
                     state_nxt = sbo_pkg::st_rd;
                     bus_req_nxt = 1'b1;
                     bus_write_nxt = 1'b0;
                     bus_io_nxt = 1'b1;
                     bus_addr_nxt = req_addr;
                  end
                  sbo_pkg::op_int_ack: begin
                     // no lock: vector fetch runs unlocked
                     state_nxt = sbo_pkg::st_rd;
                     bus_req_nxt = 1'b1;
                     bus_write_nxt = 1'b0;
                     bus_io_nxt = 1'b0;
                     bus_lock_nxt = 1'b0;
                     bus_inta_nxt = 1'b1;
                     bus_addr_nxt = req_addr;
                  end
                  // no privilege check: locked ops taken unconditionally
                  default: begin
                     // drain first: output, serializing and locked ops
                     state_nxt = sbo_pkg::st_flush;
                     flushing_nxt = 1'b1;
                  end
               endcase
            end else if (!wb.empty) begin
               // oldest first: only the head entry goes out
               state_nxt = sbo_pkg::st_wb;
               ready_nxt = 1'b0;
               bus_req_nxt = 1'b1;
               bus_write_nxt = 1'b1;
               bus_io_nxt = 1'b0;
               bus_addr_nxt = wb.head_addr;
               bus_wdata_nxt = wb.head_data;
            end
         end
         sbo_pkg::st_rd: begin
            // reads complete alone, no read ordering is tracked
            if (bus_ack) begin
               state_nxt = sbo_pkg::st_idle;
               bus_req_nxt = 1'b0;
               bus_io_nxt = 1'b0;
               bus_inta_nxt = 1'b0;
               rsp_valid_nxt = 1'b1;
               rsp_data_nxt = bus_rdata;
               ready_nxt = (wb.level < sbo_pkg::LVL_FULL);
            end
         end
         sbo_pkg::st_wb: begin
            // pop on ack: entry leaves only once the write is done
            if (bus_ack) begin
               wb.pop = 1'b1;
               bus_req_nxt = 1'b0;
               bus_write_nxt = 1'b0;
               state_nxt = flushing_r ? sbo_pkg::st_flush : sbo_pkg::st_idle;
               ready_nxt = !flushing_r;
            end
         end
         sbo_pkg::st_flush: begin
            if (!wb.empty) begin
               state_nxt = sbo_pkg::st_wb;
               bus_req_nxt = 1'b1;
               bus_write_nxt = 1'b1;
               bus_io_nxt = 1'b0;
               bus_addr_nxt = wb.head_addr;
               bus_wdata_nxt = wb.head_data;
            end else begin
               flushing_nxt = 1'b0;
               unique case (op_r)
                  sbo_pkg::op_io_wr: begin
                     // io bypass: issued directly, never queued
                     state_nxt = sbo_pkg::st_io_wr;
                     bus_req_nxt = 1'b1;
                     bus_write_nxt = 1'b1;
                     bus_io_nxt = 1'b1;
                     bus_addr_nxt = addr_r;
                     bus_wdata_nxt = wdata_r;
                  end
                  sbo_pkg::op_lock_rmw: begin
                     if (split_r) begin
                        // split locked: lock raised with the first read
                        // lock extent: whole bus held, more than the operand
                        state_nxt = sbo_pkg::st_lk_rd;
                        bus_req_nxt = 1'b1;
                        bus_write_nxt = 1'b0;
                        bus_io_nxt = 1'b0;
                        bus_lock_nxt = 1'b1;
                        bus_addr_nxt = addr_r;
                     end else begin
                        // cache only: no bus cycle, no lock
                        state_nxt = sbo_pkg::st_cache;
                        cache_req_nxt = 1'b1;
                        cache_addr_nxt = addr_r;
                        cache_wdata_nxt = wdata_r;
                     end
                  end
                  default: begin
                     // sync done: buffer empty, next op may proceed
                     state_nxt = sbo_pkg::st_idle;
                     rsp_valid_nxt = 1'b1;
                     ready_nxt = 1'b1;
                  end
               endcase
            end
         end
         sbo_pkg::st_io_wr: begin
            // output completes before the core is released
            if (bus_ack) begin
               state_nxt = sbo_pkg::st_idle;
               bus_req_nxt = 1'b0;
               bus_write_nxt = 1'b0;
               bus_io_nxt = 1'b0;
               rsp_valid_nxt = 1'b1;
               ready_nxt = 1'b1;
            end
         end
         sbo_pkg::st_lk_rd: begin
            // lock held: read turns straight into the write
            if (bus_ack) begin
               state_nxt = sbo_pkg::st_lk_wr;
               rsp_data_nxt = bus_rdata;
               bus_write_nxt = 1'b1;
               bus_wdata_nxt = wdata_r;
            end
         end
         sbo_pkg::st_lk_wr: begin
            // lock release: only after the final write is acked
            if (bus_ack) begin
               state_nxt = sbo_pkg::st_idle;
               bus_req_nxt = 1'b0;
               bus_write_nxt = 1'b0;
               bus_lock_nxt = 1'b0;
               rsp_valid_nxt = 1'b1;
               ready_nxt = 1'b1;
            end
         end
         sbo_pkg::st_cache: begin
            if (cache_ack) begin
               state_nxt = sbo_pkg::st_idle;
               cache_req_nxt = 1'b0;
               rsp_valid_nxt = 1'b1;
               rsp_data_nxt = cache_rdata;
               ready_nxt = 1'b1;
            end
         end
         default: begin
            state_nxt = sbo_pkg::st_idle;
            ready_nxt = 1'b1;
            bus_req_nxt = 1'b0;
            bus_lock_nxt = 1'b0;
            cache_req_nxt = 1'b0;
         end
      endcase
   end

   // one register stage for all control; outputs come only from here
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= sbo_pkg::st_idle;
         op_r <= sbo_pkg::op_load;
         addr_r <= sbo_pkg::ADDR_RST;
         wdata_r <= sbo_pkg::DATA_RST;
         split_r <= 1'b0;
         flushing_r <= 1'b0;
         ready_r <= 1'b1;
         rsp_valid_r <= 1'b0;
         rsp_data_r <= sbo_pkg::DATA_RST;
         bus_req_r <= 1'b0;
         bus_write_r <= 1'b0;
         bus_io_r <= 1'b0;
         bus_lock_r <= 1'b0;
         bus_inta_r <= 1'b0;
         bus_addr_r <= sbo_pkg::ADDR_RST;
         bus_wdata_r <= sbo_pkg::DATA_RST;
         cache_req_r <= 1'b0;
         cache_addr_r <= sbo_pkg::ADDR_RST;
         cache_wdata_r <= sbo_pkg::DATA_RST;
      end else begin
         state_r <= state_nxt;
         op_r <= op_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         split_r <= split_nxt;
         flushing_r <= flushing_nxt;
         ready_r <= ready_nxt;
         rsp_valid_r <= rsp_valid_nxt;
         rsp_data_r <= rsp_data_nxt;
         bus_req_r <= bus_req_nxt;
         bus_write_r <= bus_write_nxt;
         bus_io_r <= bus_io_nxt;
         bus_lock_r <= bus_lock_nxt;
         bus_inta_r <= bus_inta_nxt;
         bus_addr_r <= bus_addr_nxt;
         bus_wdata_r <= bus_wdata_nxt;
         cache_req_r <= cache_req_nxt;
         cache_addr_r <= cache_addr_nxt;
         cache_wdata_r <= cache_wdata_nxt;
      end
   end
endmodule // store_buffer_ordering_lock

// ===== sbo_properties.sv
// concurrent checks on the ports of the ordering block
`timescale 1ns/1ps
module sbo_properties (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire sbo_pkg::req_op_t req_op,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire logic bus_req,
   input wire logic bus_write,
   input wire logic bus_io,
   input wire logic bus_lock,
   input wire logic bus_inta,
   input wire logic [sbo_pkg::ADDR_W-1:0] bus_addr,
   input wire logic [sbo_pkg::DATA_W-1:0] bus_wdata,
   input wire logic bus_ack,
   input wire logic cache_req
);
   // shadow of the buffer fill, counted from takes and drained writes
   logic [3:0] pend_r;
   logic [3:0] pend_nxt;
   sbo_pkg::req_op_t last_r;
   sbo_pkg::req_op_t last_nxt;
   logic take;
   logic drain;
   assign take = req_valid && req_ready;
   assign drain = bus_req && bus_ack && bus_write && !bus_io && !bus_lock;
   always_comb begin
      pend_nxt = pend_r + {3'h0, take && req_op == sbo_pkg::op_store} - {3'h0, drain};
      last_nxt = take ? req_op : last_r;
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pend_r <= 4'h0;
         last_r <= sbo_pkg::op_load;
      end else begin
         pend_r <= pend_nxt;
         last_r <= last_nxt;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   inta_unlocked_a:
      assert property (bus_inta |-> !bus_lock) else $error("lock during vector read");
   cache_only_a:
      assert property (cache_req |-> !bus_lock && !bus_req) else $error("in-line lock used bus");
   store_retire_a:
      assert property (take && req_op == sbo_pkg::op_store |=> !rsp_valid && !bus_req)
      else $error("store waited on bus");
   io_direct_a:
      assert property (bus_req && bus_ack && bus_io && bus_write |=> rsp_valid && !bus_req)
      else $error("port write not done on ack");
   io_drained_a:
      assert property (bus_req && bus_io && bus_write |-> pend_r == 4'h0)
      else $error("port write ahead of stores");
   sync_empty_a:
      assert property (rsp_valid && (last_r == sbo_pkg::op_serialize
         || last_r == sbo_pkg::op_io_wr) |-> pend_r == 4'h0) else $error("sync with stores left");
   split_hold_a:
      assert property (bus_lock && bus_ack && !bus_write |=> bus_req && bus_lock && bus_write
         && $stable(bus_addr)) else $error("split lock broken");
   lock_drained_a:
      assert property (bus_lock |-> bus_req && pend_r == 4'h0) else $error("lock with stores left");
   bus_hold_a:
      assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr)
         && $stable(bus_wdata) && $stable(bus_write)) else $error("bus cycle changed early");
   lock_done_a:
      assert property (take && req_op == sbo_pkg::op_lock_rmw |-> ##[2:200] rsp_valid)
      else $error("locked op never done");
endmodule // sbo_properties

bind store_buffer_ordering_lock sbo_properties u_props (.*);

// ===== sys_bus_model.sv
// behavioural memory and cache behind the system bus
`timescale 1ns/1ps
module sys_bus_model #(parameter logic [31:0] VEC = 32'h0000_0042) (
   input wire logic clk,
   input wire logic [3:0] lat,
   input wire logic bus_req,
   input wire logic bus_write,
   input wire logic bus_inta,
   input wire logic [31:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   output logic bus_ack,
   output logic [31:0] bus_rdata,
   input wire logic cache_req,
   input wire logic [31:0] cache_addr,
   input wire logic [31:0] cache_wdata,
   output logic cache_ack,
   output logic [31:0] cache_rdata
);
   logic [31:0] mem [16];
   logic [3:0] wait_r = 4'h0;
   initial begin
      bus_ack = 1'b0;
      cache_ack = 1'b0;
      bus_rdata = 32'h0;
      cache_rdata = 32'h0;
      for (int i = 0; i < 16; i++) mem[i] = 32'ha5a5_0000 + 32'(i);
   end
   // data lines toggle outside the ack so a stale word is never mistaken for data
   always @(posedge clk) begin
      bus_rdata <= ~bus_rdata;
      cache_rdata <= ~cache_rdata;
      if (bus_ack || cache_ack) begin
         bus_ack <= 1'b0;
         cache_ack <= 1'b0;
         wait_r <= 4'h0;
      end else if (bus_req || cache_req) begin
         if (wait_r < lat) begin
            wait_r <= wait_r + 4'h1;
         end else if (bus_req) begin
            bus_ack <= 1'b1;
            bus_rdata <= bus_inta ? VEC : mem[bus_addr[5:2]];
            if (bus_write) mem[bus_addr[5:2]] <= bus_wdata;
         end else begin
            cache_ack <= 1'b1;
            cache_rdata <= mem[cache_addr[5:2]];
            mem[cache_addr[5:2]] <= cache_wdata;
         end
      end
   end
endmodule // sys_bus_model

// ===== store_buffer_ordering_lock_tb_top.sv
// self-checking bench for the store buffer and ordering block
`timescale 1ns/1ps
module store_buffer_ordering_lock_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   sbo_pkg::req_op_t req_op = sbo_pkg::op_load;
   logic [31:0] req_addr = 32'h0;
   logic [31:0] req_wdata = 32'h0;
   logic req_split = 1'b0;
   logic req_ready, rsp_valid, bus_req, bus_write, bus_io, bus_lock, bus_inta;
   logic bus_ack, cache_req, cache_ack;
   logic [31:0] rsp_rdata, bus_addr, bus_wdata, bus_rdata, cache_addr, cache_wdata, cache_rdata;
   logic [3:0] lat = 4'h0;
   logic [31:0] log_q [$];
   logic [31:0] d;
   int errors = 0;
   int compares = 0;

   always #12.5 clk = ~clk;

   store_buffer_ordering_lock u_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
      .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .req_split(req_split),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .bus_req(bus_req),
      .bus_write(bus_write), .bus_io(bus_io), .bus_lock(bus_lock), .bus_inta(bus_inta),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
      .cache_req(cache_req), .cache_addr(cache_addr), .cache_wdata(cache_wdata),
      .cache_ack(cache_ack), .cache_rdata(cache_rdata));

   sys_bus_model u_bus (.clk(clk), .lat(lat), .bus_req(bus_req), .bus_write(bus_write),
      .bus_inta(bus_inta), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
      .bus_rdata(bus_rdata), .cache_req(cache_req), .cache_addr(cache_addr),
      .cache_wdata(cache_wdata), .cache_ack(cache_ack), .cache_rdata(cache_rdata));

   // log entry: write, io, lock, low address bits
   always @(posedge clk) begin
      if (bus_req === 1'b1 && bus_ack === 1'b1)
         log_q.push_back({bus_write, bus_io, bus_lock, bus_addr[28:0]});
   end

   task automatic chk_bit(logic got, logic exp, string what);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t %s", $time, what);
      end
   endtask

   task automatic chk_word(logic [31:0] got, logic [31:0] exp, string what);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic expect_log(logic [31:0] exp, string what);
      chk_word(log_q.size() > 0 ? log_q.pop_front() : 32'hffff_ffff, exp, what);
   endtask

   // leaves valid high so requests can follow back to back
   task automatic issue(sbo_pkg::req_op_t op, logic [31:0] a, logic [31:0] w, logic s);
      int n;
      n = 0;
      req_valid = 1'b1;
      req_op = op;
      req_addr = a;
      req_wdata = w;
      req_split = s;
      do begin
         @(posedge clk);
         n++;
      end while (req_ready !== 1'b1 && n < 300);
      if (n >= 300) chk_bit(1'b0, 1'b1, "request not taken");
      #1;
   endtask

   task automatic wait_rsp;
      int n;
      n = 0;
      req_valid = 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 300);
      d = rsp_rdata;
      if (n >= 300) chk_bit(1'b0, 1'b1, "no response");
      #1;
   endtask

   task automatic t_fill;
      lat = 4'h3;
      for (int i = 0; i < 4; i++) issue(sbo_pkg::op_store, 32'(i * 4), 32'h1100_0000 + 32'(i), 1'b0);
      req_valid = 1'b0;
      @(posedge clk);
      chk_bit(req_ready, 1'b0, "ready while full");
      chk_word(32'(log_q.size()), 32'h0, "store waited for bus");
      #1;
      issue(sbo_pkg::op_serialize, 32'h0, 32'h0, 1'b0);
      wait_rsp;
      chk_word(32'(log_q.size()), 32'h4, "sync before drain");
      for (int i = 0; i < 4; i++) expect_log(32'h8000_0000 + 32'(i * 4), "drain order");
   endtask

   task automatic t_fwd;
      lat = 4'h5;
      issue(sbo_pkg::op_store, 32'h10, 32'h2222_0001, 1'b0);
      issue(sbo_pkg::op_store, 32'h10, 32'h2222_0002, 1'b0);
      issue(sbo_pkg::op_load, 32'h10, 32'h0, 1'b0);
      req_valid = 1'b0;
      @(posedge clk);
      chk_bit(rsp_valid, 1'b1, "forward latency");
      chk_word(rsp_rdata, 32'h2222_0002, "forward data");
      #1;
      issue(sbo_pkg::op_serialize, 32'h0, 32'h0, 1'b0);
      wait_rsp;
      for (int i = 0; i < 2; i++) expect_log(32'h8000_0010, "same address drain");
   endtask

   task automatic t_pass;
      lat = 4'h6;
      issue(sbo_pkg::op_store, 32'h18, 32'h3333_0000, 1'b0);
      issue(sbo_pkg::op_load, 32'h1c, 32'h0, 1'b0);
      wait_rsp;
      chk_word(d, 32'ha5a5_0007, "load data");
      expect_log(32'h0000_001c, "read passes store");
      issue(sbo_pkg::op_serialize, 32'h0, 32'h0, 1'b0);
      wait_rsp;
      expect_log(32'h8000_0018, "late store");
   endtask

   task automatic t_io;
      lat = 4'h0;
      issue(sbo_pkg::op_store, 32'h20, 32'h4444_0000, 1'b0);
      issue(sbo_pkg::op_io_wr, 32'h24, 32'h5555_0000, 1'b0);
      wait_rsp;
      expect_log(32'h8000_0020, "store before port write");
      expect_log(32'hc000_0024, "port write direct");
      issue(sbo_pkg::op_io_rd, 32'h28, 32'h0, 1'b0);
      wait_rsp;
      chk_word(d, 32'ha5a5_000a, "port read data");
      expect_log(32'h4000_0028, "port read");
      chk_word(32'(log_q.size()), 32'h0, "port write repeated");
   endtask

   task automatic t_lock;
      lat = 4'h2;
      issue(sbo_pkg::op_lock_rmw, 32'h2c, 32'h6666_0000, 1'b0);
      wait_rsp;
      chk_word(d, 32'ha5a5_000b, "in-line old value");
      chk_word(32'(log_q.size()), 32'h0, "in-line used bus");
      issue(sbo_pkg::op_load, 32'h2c, 32'h0, 1'b0);
      wait_rsp;
      chk_word(d, 32'h6666_0000, "in-line cache write");
      expect_log(32'h0000_002c, "in-line readback");
      issue(sbo_pkg::op_lock_rmw, 32'h30, 32'h7777_0000, 1'b1);
      wait_rsp;
      chk_word(d, 32'ha5a5_000c, "split old value");
      expect_log(32'h2000_0030, "locked read");
      expect_log(32'ha000_0030, "locked write");
      issue(sbo_pkg::op_load, 32'h30, 32'h0, 1'b0);
      wait_rsp;
      chk_word(d, 32'h7777_0000, "locked result");
      log_q.delete();
   endtask

   task automatic t_inta;
      issue(sbo_pkg::op_int_ack, 32'h0, 32'h0, 1'b0);
      wait_rsp;
      chk_word(d, 32'h0000_0042, "vector");
      chk_word(32'(log_q.size()), 32'h1, "ack cycles");
      chk_bit(log_q[0][29], 1'b0, "lock during ack");
      log_q.delete();
   endtask

   task automatic conclude;
      if (errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_fill;
      t_fwd;
      t_pass;
      t_io;
      t_lock;
      t_inta;
      conclude;
   end

   // the scenarios need well under a thousand cycles; this allows forty times that
   initial begin
      #1000000;
      errors++;
      conclude;
   end
endmodule // store_buffer_ordering_lock_tb_top
